/* hw/afh_aux_handshake.sv */
`timescale 1ns/10ps
`default_nettype none

module afh_aux_handshake
(
  // Clock and reset
  input  wire logic                i_clk_sys,
  input  wire logic                i_nrst,
  // AHB-Lite slave
  input  wire logic                i_hsel,
  input  wire logic [31:0]         i_haddr,
  input  wire logic [1:0]          i_htrans,
  input  wire logic                i_hwrite,
  input  wire logic [2:0]          i_hsize,
  input  wire logic                i_hready,
  input  wire logic [31:0]         i_hwdata,
  output logic      [31:0]         o_hrdata,
  output logic                     o_hreadyout,
  output logic      [1:0]          o_hresp,
  // PLC side
  input  wire logic                i_completion_ack,
  output afh_pkg::afh_plc_out_s    o_plc
);

  // ****************************************************************
  // State
  // ****************************************************************
  afh_pkg::afh_regs_s r_r;
  afh_pkg::afh_regs_s r_nxt;

  logic        cmd_wr;
  logic [31:0] cmd_word;
  logic [2:0]  mcnt;
  logic [2:0]  hcnt;
  logic [2:0]  scnt;
  logic [31:0] min_cyc;
  logic        ns_m;

  // ****************************************************************
  // Register read mux
  // ****************************************************************
  function automatic logic [31:0] read_reg(input afh_pkg::afh_regs_s s, input logic [7:0] a,
                                           input logic ack);
    logic [31:0] v;
    v = '0;
    if (a == afh_pkg::ADDR_MIN_TIME)
    begin
      v = s.min_strobe_time;
    end
    else if (a == afh_pkg::ADDR_STATUS)
    begin
      v[afh_pkg::ST_BUSY_BIT]  = (s.st != afh_pkg::ST_IDLE);
      v[afh_pkg::ST_GAP_BIT]   = (s.st == afh_pkg::ST_GAP);
      v[afh_pkg::ST_MSTB_BIT]  = s.plc.mcode_strobe;
      v[afh_pkg::ST_HSTB_BIT]  = s.plc.hcode_strobe;
      v[afh_pkg::ST_SSTB_BIT]  = s.plc.spindle_strobe;
      v[afh_pkg::ST_ACK_BIT]   = ack;
      v[afh_pkg::ST_ACKLO_BIT] = s.ack_low_seen;
      v[afh_pkg::ST_BLOCKS_LSB +: 16] = s.blocks_done;
    end
    else if (a[7:5] == afh_pkg::MSTAGE_BASE && a[4:2] != 3'h7)
    begin
      v = s.m_stage[a[4:2]];
    end
    else if (a[7:5] == afh_pkg::HSTAGE_BASE && a[4:2] != 3'h7)
    begin
      v = s.h_stage[a[4:2]];
    end
    else if (a[7:4] == afh_pkg::SSTAGE_BASE)
    begin
      v = s.s_stage[a[3:2]];
    end
    return v;
  endfunction

  // ****************************************************************
  // Next-state logic
  // ****************************************************************
  always_comb
  begin
    r_nxt    = r_r;
    cmd_wr   = 1'b0;
    cmd_word = i_hwdata;
    mcnt     = cmd_word[afh_pkg::CMD_MCNT_LSB +: 3];
    hcnt     = cmd_word[afh_pkg::CMD_HCNT_LSB +: 3];
    scnt     = cmd_word[afh_pkg::CMD_SCNT_LSB +: 3];
    // A zero setting would give no visible pulse, so one cycle is the floor.
    min_cyc  = (r_r.min_strobe_time == 32'h00000000) ? 32'h00000001 : r_r.min_strobe_time;
    ns_m     = r_r.plc.mcode_strobe && !r_r.m_sync;

    // Data phase of a write accepted on the previous edge.
    if (r_r.wr_pend)
    begin
      if (r_r.wr_addr == afh_pkg::ADDR_CMD)
      begin
        cmd_wr = 1'b1;
      end
      else if (r_r.wr_addr == afh_pkg::ADDR_MIN_TIME)
      begin
        r_nxt.min_strobe_time = i_hwdata;
      end
      else if (r_r.wr_addr[7:5] == afh_pkg::MSTAGE_BASE && r_r.wr_addr[4:2] != 3'h7)
      begin
        r_nxt.m_stage[r_r.wr_addr[4:2]] = i_hwdata;
      end
      else if (r_r.wr_addr[7:5] == afh_pkg::HSTAGE_BASE && r_r.wr_addr[4:2] != 3'h7)
      begin
        r_nxt.h_stage[r_r.wr_addr[4:2]] = i_hwdata;
      end
      else if (r_r.wr_addr[7:4] == afh_pkg::SSTAGE_BASE)
      begin
        r_nxt.s_stage[r_r.wr_addr[3:2]] = i_hwdata;
      end
    end

    // Address phase; read data is taken from the already-updated copy so that
    // a read right behind a write to the same register sees the new value.
    r_nxt.wr_pend = 1'b0;
    if (i_hsel && i_htrans[1] && i_hready)
    begin
      r_nxt.wr_pend = i_hwrite;
      r_nxt.wr_addr = i_haddr[7:0];
      if (!i_hwrite)
      begin
        r_nxt.rdata = read_reg(r_nxt, i_haddr[7:0], i_completion_ack);
      end
    end

    unique case (r_r.st)
      afh_pkg::ST_IDLE:
      begin
        // A command while busy is dropped; software polls the busy bit first.
        if (cmd_wr && (mcnt != 3'h0 || hcnt != 3'h0 || scnt != 3'h0))
        begin
          for (int i = 0; i < afh_pkg::NUM_MCODE; i++)
          begin
            r_nxt.plc.mcode[i] = (3'(i) < mcnt) ? r_r.m_stage[i] : afh_pkg::CODE_UNUSED;
            r_nxt.plc.hcode[i] = (3'(i) < hcnt) ? r_r.h_stage[i] : afh_pkg::CODE_UNUSED;
          end
          for (int i = 0; i < afh_pkg::NUM_SPINDLE; i++)
          begin
            r_nxt.plc.spindle_value[i] = (3'(i) < scnt) ? r_r.s_stage[i] : afh_pkg::CODE_UNUSED;
          end
          r_nxt.plc.mcode_strobe   = (mcnt != 3'h0);
          r_nxt.plc.hcode_strobe   = (hcnt != 3'h0);
          r_nxt.plc.spindle_strobe = (scnt != 3'h0);
          r_nxt.m_sync       = cmd_word[afh_pkg::CMD_MSYNC_BIT];
          // Spindle values always wait for the acknowledge, M codes only when asked.
          r_nxt.sync_on      = (scnt != 3'h0) || (mcnt != 3'h0 && cmd_word[afh_pkg::CMD_MSYNC_BIT]);
          r_nxt.had_ns       = (hcnt != 3'h0) || (mcnt != 3'h0 && !cmd_word[afh_pkg::CMD_MSYNC_BIT]);
          r_nxt.ack_low_seen = 1'b0;
          r_nxt.ns_cnt       = min_cyc;
          r_nxt.ack_cnt      = min_cyc;
          r_nxt.st           = afh_pkg::ST_RUN;
        end
      end

      afh_pkg::ST_RUN:
      begin
        // Unsynchronized strobes run on the timer alone, the acknowledge is not looked at.
        if (r_r.plc.hcode_strobe || ns_m)
        begin
          if (r_r.ns_cnt == 32'h00000001)
          begin
            r_nxt.plc.hcode_strobe = 1'b0;
            if (ns_m)
            begin
              r_nxt.plc.mcode_strobe = 1'b0;
            end
          end
          else
          begin
            r_nxt.ns_cnt = r_r.ns_cnt - 32'h00000001;
          end
        end

        if (r_r.sync_on)
        begin
          if (!r_r.ack_low_seen)
          begin
            // The PLC marks the start of execution by pulling the acknowledge low.
            r_nxt.ack_low_seen = !i_completion_ack;
          end
          else if (i_completion_ack)
          begin
            // A high acknowledge must outlast the minimum time, so it takes one
            // cycle more than the setting; a shorter glitch restarts the count.
            if (r_r.ack_cnt == 32'h00000000)
            begin
              r_nxt.sync_on            = 1'b0;
              r_nxt.plc.spindle_strobe = 1'b0;
              if (r_r.m_sync)
              begin
                r_nxt.plc.mcode_strobe = 1'b0;
              end
            end
            else
            begin
              r_nxt.ack_cnt = r_r.ack_cnt - 32'h00000001;
            end
          end
          else
          begin
            r_nxt.ack_cnt = min_cyc;
          end
        end

        if (!r_r.sync_on && !r_r.plc.mcode_strobe && !r_r.plc.hcode_strobe && !r_r.plc.spindle_strobe)
        begin
          r_nxt.blocks_done = r_r.blocks_done + 16'h0001;
          r_nxt.ns_cnt      = min_cyc;
          // Busy stays set through ST_GAP after timed transfers; it clears here only for blocks with no timed strobe.
          r_nxt.st          = r_r.had_ns ? afh_pkg::ST_GAP : afh_pkg::ST_IDLE;
        end
      end

      afh_pkg::ST_GAP:
      begin
        // Gives a slow PLC scan time to read the codes before they are replaced.
        if (r_r.ns_cnt == 32'h00000001)
        begin
          r_nxt.st = afh_pkg::ST_IDLE;
        end
        else
        begin
          r_nxt.ns_cnt = r_r.ns_cnt - 32'h00000001;
        end
      end

      default:
      begin
        r_nxt.st = afh_pkg::ST_IDLE;
      end
    endcase
  end

  // ****************************************************************
  // State register
  // ****************************************************************
  always_ff @(posedge i_clk_sys or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      r_r                    <= '0;
      r_r.st                 <= afh_pkg::ST_IDLE;
      r_r.min_strobe_time    <= afh_pkg::MIN_STROBE_CYC;
      r_r.plc.mcode          <= {afh_pkg::NUM_MCODE{afh_pkg::CODE_UNUSED}};
      r_r.plc.hcode          <= {afh_pkg::NUM_HCODE{afh_pkg::CODE_UNUSED}};
      r_r.plc.spindle_value  <= {afh_pkg::NUM_SPINDLE{afh_pkg::CODE_UNUSED}};
    end
    else
    begin
      r_r <= r_nxt;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign o_hrdata    = r_r.rdata;
  assign o_hreadyout = 1'b1;
  assign o_hresp     = afh_pkg::HRESP_OKAY;
  assign o_plc       = r_r.plc;

endmodule

`default_nettype wire

/* hw/afh_pkg.sv */
package afh_pkg;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int          CLK_PERIOD_NS      = 10;
  localparam int          MIN_STROBE_TIME_NS = 1000;
  localparam logic [31:0] MIN_STROBE_CYC     =
    32'((MIN_STROBE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  // ****************************************************************
  // Register map (byte addresses, low eight address bits decoded)
  // ****************************************************************
  localparam logic [7:0]  ADDR_CMD      = 8'h00;
  localparam logic [7:0]  ADDR_MIN_TIME = 8'h04;
  localparam logic [7:0]  ADDR_STATUS   = 8'h08;
  localparam logic [2:0]  MSTAGE_BASE   = 3'h1;
  localparam logic [2:0]  HSTAGE_BASE   = 3'h2;
  localparam logic [3:0]  SSTAGE_BASE   = 4'h6;

  // Command word fields.
  localparam int          CMD_MCNT_LSB  = 0;
  localparam int          CMD_HCNT_LSB  = 3;
  localparam int          CMD_SCNT_LSB  = 6;
  localparam int          CMD_MSYNC_BIT = 9;

  // Status word fields.
  localparam int          ST_BUSY_BIT   = 0;
  localparam int          ST_GAP_BIT    = 1;
  localparam int          ST_MSTB_BIT   = 2;
  localparam int          ST_HSTB_BIT   = 3;
  localparam int          ST_SSTB_BIT   = 4;
  localparam int          ST_ACK_BIT    = 5;
  localparam int          ST_ACKLO_BIT  = 6;
  localparam int          ST_BLOCKS_LSB = 16;

  // ****************************************************************
  // Sizes and reset values
  // ****************************************************************
  localparam int          NUM_MCODE     = 7;
  localparam int          NUM_HCODE     = 7;
  localparam int          NUM_SPINDLE   = 4;
  localparam logic [31:0] CODE_UNUSED   = 32'hFFFFFFFF;
  localparam logic [1:0]  HRESP_OKAY    = 2'h0;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [1:0] {ST_IDLE, ST_RUN, ST_GAP} afh_state_e;

  typedef struct packed {
    logic [NUM_MCODE-1:0][31:0]   mcode;
    logic [NUM_HCODE-1:0][31:0]   hcode;
    logic [NUM_SPINDLE-1:0][31:0] spindle_value;
    logic                         mcode_strobe;
    logic                         hcode_strobe;
    logic                         spindle_strobe;
  } afh_plc_out_s;

  typedef struct packed {
    afh_state_e                   st;
    logic [31:0]                  min_strobe_time;
    logic [NUM_MCODE-1:0][31:0]   m_stage;
    logic [NUM_HCODE-1:0][31:0]   h_stage;
    logic [NUM_SPINDLE-1:0][31:0] s_stage;
    afh_plc_out_s                 plc;
    logic                         m_sync;
    logic                         sync_on;
    logic                         had_ns;
    logic                         ack_low_seen;
    logic [31:0]                  ns_cnt;
    logic [31:0]                  ack_cnt;
    logic [15:0]                  blocks_done;
    logic                         wr_pend;
    logic [7:0]                   wr_addr;
    logic [31:0]                  rdata;
  } afh_regs_s;

endpackage

/* verification/afh_aux_monitor.sv */
`timescale 1ns/10ps
`default_nettype none

module afh_aux_monitor
(
  // Clock, reset and bus
  input  wire logic                  i_clk_sys,
  input  wire logic                  i_nrst,
  input  wire logic                  i_hsel,
  input  wire logic [31:0]           i_haddr,
  input  wire logic [1:0]            i_htrans,
  input  wire logic                  i_hwrite,
  input  wire logic                  i_hready,
  input  wire logic [31:0]           i_hwdata,
  // PLC side
  input  wire logic                  i_completion_ack,
  input  wire afh_pkg::afh_plc_out_s i_plc
);
  // ****************************************************************
  // Shadow of the minimum time and run-length counters
  // ****************************************************************
  logic        wp_r;
  logic [7:0]  wa_r;
  logic [31:0] n_r;
  logic [31:0] hc_r;
  logic [31:0] ac_r;

  // The minimum time is tracked from bus writes, so no hierarchy probing is needed.
  always_ff @(posedge i_clk_sys or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      wp_r <= 1'b0;
      wa_r <= 8'h00;
      n_r  <= afh_pkg::MIN_STROBE_CYC;
      hc_r <= 32'h0;
      ac_r <= 32'h0;
    end
    else
    begin
      wp_r <= i_hsel && i_htrans[1] && i_hready && i_hwrite;
      // The address is kept only when a transfer is taken, as the slave does.
      if (i_hsel && i_htrans[1] && i_hready)
      begin
        wa_r <= i_haddr[7:0];
      end
      if (wp_r && wa_r == afh_pkg::ADDR_MIN_TIME)
        n_r <= (i_hwdata == 32'h0) ? 32'h1 : i_hwdata;
      hc_r <= i_plc.hcode_strobe ? hc_r + 32'h1 : 32'h0;
      ac_r <= i_completion_ack ? ac_r + 32'h1 : 32'h0;
    end
  end

  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!i_nrst);

  chk_h_pulse_len: assert property ($fell(i_plc.hcode_strobe) |-> hc_r == n_r)
    else $error("H strobe width differs from minimum time");
  chk_h_no_over: assert property (i_plc.hcode_strobe |-> hc_r < n_r)
    else $error("H strobe held beyond minimum time");
  chk_s_ack_long: assert property ($fell(i_plc.spindle_strobe) |-> ac_r > n_r)
    else $error("Spindle strobe fell without a long acknowledge");
  chk_one_ack_all: assert property ($fell(i_plc.spindle_strobe) |-> !i_plc.mcode_strobe)
    else $error("Synchronized strobes not ended together");
  chk_h_codes_hold: assert property (i_plc.hcode_strobe && $past(i_plc.hcode_strobe) |-> $stable(i_plc.hcode))
    else $error("H codes changed under strobe");
  chk_m_codes_hold: assert property (i_plc.mcode_strobe && $past(i_plc.mcode_strobe) |-> $stable(i_plc.mcode))
    else $error("M codes changed under strobe");
  chk_s_vals_hold: assert property (i_plc.spindle_strobe && $past(i_plc.spindle_strobe)
    |-> $stable(i_plc.spindle_value))
    else $error("Spindle values changed under strobe");
  chk_s_min_len: assert property ($rose(i_plc.spindle_strobe) |-> i_plc.spindle_strobe[*2])
    else $error("Spindle strobe too short for a handshake");

  cov_h_done: cover property ($fell(i_plc.hcode_strobe));
  cov_m_done: cover property ($fell(i_plc.mcode_strobe));
  cov_s_done: cover property ($fell(i_plc.spindle_strobe));
endmodule

bind afh_aux_handshake afh_aux_monitor afh_aux_monitor_i (.i_clk_sys, .i_nrst, .i_hsel, .i_haddr, .i_htrans,
  .i_hwrite, .i_hready, .i_hwdata, .i_completion_ack, .i_plc(o_plc));

`default_nettype wire

/* verification/afh_plc_model.sv */
`timescale 1ns/10ps
`default_nettype none

module afh_plc_model
(
  // Clock and reset
  input  wire logic                  i_clk_sys,
  input  wire logic                  i_nrst,
  // Test controls
  input  wire logic [7:0]            i_delay,
  input  wire logic                  i_glitch,
  // Device side
  input  wire afh_pkg::afh_plc_out_s i_plc,
  output logic                       o_completion_ack
);
  logic want;

  assign want = i_plc.mcode_strobe | i_plc.spindle_strobe;

  // Acts on every clock, so its scan is never slower than the minimum time.
  always
  begin
    @(posedge i_clk_sys);
    if (!i_nrst)
      o_completion_ack <= 1'b1;
    else if (want && o_completion_ack)
    begin
      o_completion_ack <= 1'b0;
      @(posedge i_clk_sys);
      repeat (i_delay) @(posedge i_clk_sys);
      if (i_glitch)
      begin
        // A one-cycle blip is too short and must not end the transfer.
        o_completion_ack <= 1'b1;
        @(posedge i_clk_sys);
        o_completion_ack <= 1'b0;
        @(posedge i_clk_sys);
      end
      o_completion_ack <= 1'b1;
      @(posedge i_clk_sys);
      while (want) @(posedge i_clk_sys);
    end
  end
endmodule

`default_nettype wire

/* verification/tb.sv */
`timescale 1ns/10ps
`default_nettype none

module tb;
  logic                  i_clk_sys;
  logic                  i_nrst;
  logic                  i_hsel;
  logic                  i_hwrite;
  logic                  i_hready;
  logic                  o_hreadyout;
  logic                  i_completion_ack;
  logic                  glitch;
  logic [1:0]            i_htrans;
  logic [1:0]            o_hresp;
  logic [7:0]            delay;
  logic [31:0]           i_haddr;
  logic [31:0]           i_hwdata;
  logic [31:0]           o_hrdata;
  logic [31:0]           rd;
  logic [31:0]           st;
  afh_pkg::afh_plc_out_s o_plc;
  int                    bad_count = 0;
  int                    n_compared = 0;
  int                    cyc = 0;
  int                    ml;
  int                    hl;
  int                    sl;

  assign i_hready = o_hreadyout;

  afh_aux_handshake afh_aux_handshake_i (.i_clk_sys, .i_nrst, .i_hsel, .i_haddr, .i_htrans, .i_hwrite,
    .i_hsize(3'h2), .i_hready, .i_hwdata, .o_hrdata, .o_hreadyout, .o_hresp, .i_completion_ack, .o_plc);
  afh_plc_model afh_plc_model_i (.i_clk_sys, .i_nrst, .i_delay(delay), .i_glitch(glitch), .i_plc(o_plc),
    .o_completion_ack(i_completion_ack));

  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic give_verdict();
    if (bad_count == 0 && n_compared > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] wd);
    i_hsel   <= 1'b1;
    i_htrans <= 2'h2;
    i_haddr  <= {24'h0, a};
    i_hwrite <= w;
    do @(posedge i_clk_sys); while (i_hready !== 1'b1);
    i_hsel   <= 1'b0;
    i_htrans <= 2'h0;
    i_hwdata <= wd;
    do @(posedge i_clk_sys); while (i_hready !== 1'b1);
    rd = o_hrdata;
  endtask

  // Runs one block: counts strobe-high cycles, snapshots status, then waits for idle.
  task automatic blk(input logic [31:0] cmd);
    bit seen;
    ml = 0;
    hl = 0;
    sl = 0;
    seen = 0;
    bus(afh_pkg::ADDR_CMD, 1'b1, cmd);
    repeat (600)
    begin
      #1;
      ml += int'(o_plc.mcode_strobe);
      hl += int'(o_plc.hcode_strobe);
      sl += int'(o_plc.spindle_strobe);
      seen |= o_plc.mcode_strobe | o_plc.hcode_strobe | o_plc.spindle_strobe;
      if (seen && !(o_plc.mcode_strobe | o_plc.hcode_strobe | o_plc.spindle_strobe))
        break;
      @(posedge i_clk_sys);
    end
    @(posedge i_clk_sys);
    bus(afh_pkg::ADDR_STATUS, 1'b0, 32'h0);
    st = rd;
    do bus(afh_pkg::ADDR_STATUS, 1'b0, 32'h0); while (rd[afh_pkg::ST_BUSY_BIT] !== 1'b0);
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic sc_reset();
    chk("h_unused", o_plc.hcode[6], afh_pkg::CODE_UNUSED);
    chk("hresp", 32'(o_hresp), 32'(afh_pkg::HRESP_OKAY));
    chk("hreadyout", 32'(o_hreadyout), 32'h1);
    bus(afh_pkg::ADDR_MIN_TIME, 1'b0, 32'h0);
    chk("min_time", rd, afh_pkg::MIN_STROBE_CYC);
    bus(8'hF0, 1'b0, 32'h0);
    chk("unmapped", rd, 32'h0);
    bus(afh_pkg::ADDR_MIN_TIME, 1'b1, 32'h3);
    bus(afh_pkg::ADDR_MIN_TIME, 1'b0, 32'h0);
    chk("min_time_set", rd, 32'h3);
    // A command with every count at zero must not start a block.
    bus(afh_pkg::ADDR_CMD, 1'b1, 32'h0);
    bus(afh_pkg::ADDR_STATUS, 1'b0, 32'h0);
    chk("idle_busy", 32'(rd[afh_pkg::ST_BUSY_BIT]), 32'h0);
    chk("idle_ack", 32'(rd[afh_pkg::ST_ACK_BIT]), 32'h1);
    chk("idle_hstb", 32'(rd[afh_pkg::ST_HSTB_BIT]), 32'h0);
  endtask

  task automatic sc_hcodes();
    bus(8'h40, 1'b1, 32'h11);
    bus(8'h44, 1'b1, 32'h12);
    blk(32'h10);
    chk("h_len", hl, 32'h3);
    chk("m_len", ml, 32'h0);
    chk("h_first", o_plc.hcode[0], 32'h11);
    chk("h_second", o_plc.hcode[1], 32'h12);
    chk("h_spare", o_plc.hcode[2], afh_pkg::CODE_UNUSED);
    chk("h_gap", st[afh_pkg::ST_GAP_BIT], 32'h1);
  endtask

  task automatic sc_munsync();
    for (int i = 0; i < 7; i++)
      bus(8'h20 + 8'(4 * i), 1'b1, 32'h100 + 32'(i));
    blk(32'h7);
    chk("m_len", ml, 32'h3);
    chk("m_last", o_plc.mcode[6], 32'h106);
    chk("m_gap", st[afh_pkg::ST_GAP_BIT], 32'h1);
    chk("blocks", rd[31:16], 32'h2);
  endtask

  task automatic sc_sync();
    delay <= 8'h5;
    bus(8'h60, 1'b1, 32'h3E8);
    blk(32'h241);
    chk("s_len", 32'(sl >= 11 && sl <= 12), 32'h1);
    chk("m_sync_len", ml, sl);
    chk("no_gap", st[afh_pkg::ST_GAP_BIT], 32'h0);
    chk("s_first", o_plc.spindle_value[0], 32'h3E8);
    chk("s_spare", o_plc.spindle_value[1], afh_pkg::CODE_UNUSED);
    chk("m_spare", o_plc.mcode[1], afh_pkg::CODE_UNUSED);
  endtask

  task automatic sc_glitch();
    delay  <= 8'h2;
    glitch <= 1'b1;
    blk(32'h40);
    chk("s_glitch_len", 32'(sl >= 10 && sl <= 11), 32'h1);
    chk("h_none", hl, 32'h0);
  endtask

  initial
  begin
    i_clk_sys = 1'b0;
    forever #5 i_clk_sys = ~i_clk_sys;
  end

  always @(posedge i_clk_sys)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      bad_count++;
      give_verdict();
    end
  end

  initial
  begin
    i_nrst   = 1'b0;
    i_hsel   = 1'b0;
    i_htrans = 2'h0;
    i_haddr  = 32'h0;
    i_hwrite = 1'b0;
    i_hwdata = 32'h0;
    delay    = 8'h1;
    glitch   = 1'b0;
    repeat (6) @(posedge i_clk_sys);
    i_nrst <= 1'b1;
    sc_reset();
    sc_hcodes();
    sc_munsync();
    sc_sync();
    sc_glitch();
    give_verdict();
  end
endmodule

`default_nettype wire
